// File: rtl/cdp_defines.svh
// Constants of the configuration data port: widths, codes, timing counts
`ifndef CDP_DEFINES_SVH
`define CDP_DEFINES_SVH
`define CDP_ADDR_LOW_W    18
// Idle levels of the synchronised pins: selects off, strobes high
`define CDP_PIN_IDLE      14'h0b00
`define CDP_ADDR_HIGH_W   4
`define CDP_ADDR_UP_START 22'h000000
`define CDP_ADDR_DN_START 22'h3fffff
`define CDP_CLK_HZ        25000000
`define CDP_SLOW_HZ       1000000
`define CDP_FAST_HZ       8000000
// Half period counts of the generated configuration clock, rounded down
`define CDP_SLOW_HALF     ((`CDP_CLK_HZ / `CDP_SLOW_HZ) / 2)
`define CDP_FAST_HALF     ((`CDP_CLK_HZ / `CDP_FAST_HZ) / 2)
`define CDP_MODE_MSER     3'h0
`define CDP_MODE_SSER     3'h7
`define CDP_MODE_MPUP     3'h4
`define CDP_MODE_MPDN     3'h6
`define CDP_MODE_PSYN     3'h3
`define CDP_MODE_PASY     3'h5
`endif

// File: rtl/cdp_pkg.sv
// Types of the configuration data port
package cdp_pkg;
  typedef enum logic [1:0] {
    CDP_IDLE  = 2'b00,
    CDP_FETCH = 2'b01,
    CDP_SHIFT = 2'b10
  } cdp_state_type;
endpackage

// File: rtl/cdp_port.sv
// Configuration data port: peripheral byte port, PROM master, serial chain
`timescale 1ns/100ps
`include "cdp_defines.svh"
// What this block does
// - Selected while low select low, high select high
// - Selected write strobe low captures byte
// - Selected read strobe: top line status, others high
// - Both strobes low: write wins over read
// - Express mode: high select is serial enable
// - Master parallel drives 18-bit PROM address
// - Wide variant adds 4 upper address outputs
// - Peripheral modes accept bytes on eight inputs
// - Serial modes sample data on rising clock
// - Master parallel: serial input is byte bit zero
// - Forward data, change on falling, 1.5 periods later
// - Express: serial output enables downstream device
// - After configuration release all port pins
// - Up starts zero increments; down all-ones decrements
// - Master generates clock, slow then optional fast
// - Master parallel serializes each received byte
module cdp_port #(
  parameter bit WIDE_ADDR = 1'b1
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Mode and phase control
  input  wire logic [2:0]  cfg_mode,
  input  wire logic        express_mode,
  input  wire logic        fast_rate,
  input  wire logic        config_done,
  // Peripheral port
  input  wire logic        select_active_low,
  input  wire logic        select_active_high,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic [7:0]  parallel_config_bus_in,
  output logic      [7:0]  parallel_config_bus_out,
  output logic      [7:0]  parallel_config_bus_oe_n,
  // Serial chain
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_out_oe_n,
  // Configuration clock, driven in master modes, sampled otherwise
  input  wire logic        cfg_clock_in,
  output logic             cfg_clock_out,
  output logic             cfg_clock_oe_n,
  // PROM address
  output logic [17:0]      prom_addr_low,
  output logic [3:0]       prom_addr_high,
  output logic             prom_addr_oe_n,
  // Internal frame stream
  output logic             frame_bit,
  output logic             frame_bit_valid
);
  import cdp_pkg::*;

  // Two-flop synchronisers for the port, serial and clock pins, not the mode pins; reset to the idle pin
  // levels so that no false strobe or clock edge follows a reset
  logic [13:0] pin_meta_reg;
  logic [13:0] pin_sync_reg;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_reg <= `CDP_PIN_IDLE;
      pin_sync_reg <= `CDP_PIN_IDLE;
    end else begin
      pin_meta_reg <= {cfg_clock_in, serial_data_in, select_active_low,
                       select_active_high, write_strobe_n, read_strobe_n,
                       parallel_config_bus_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic       ext_clk;
  logic       din_s;
  logic       sel_n_s;
  logic       sel_s;
  logic       ws_n_s;
  logic       rs_n_s;
  logic [7:0] bus_s;
  assign {ext_clk, din_s, sel_n_s, sel_s, ws_n_s, rs_n_s, bus_s} =
         pin_sync_reg;

  // Mode decode
  logic is_master;
  logic is_mpar;
  logic is_periph;
  logic selected;
  logic do_write;
  logic do_read;
  assign is_mpar   = (cfg_mode == `CDP_MODE_MPUP) ||
                     (cfg_mode == `CDP_MODE_MPDN);
  assign is_master = is_mpar || (cfg_mode == `CDP_MODE_MSER) ||
                     (cfg_mode == `CDP_MODE_PASY);
  assign is_periph = (cfg_mode == `CDP_MODE_PASY) ||
                     (cfg_mode == `CDP_MODE_PSYN);
  assign selected  = !sel_n_s && sel_s;
  assign do_write  = is_periph && selected && !ws_n_s;
  assign do_read   = is_periph && selected && !rs_n_s && ws_n_s;

  // Strobe edge: one byte per low pulse, however long the host holds it
  logic ws_n_last_reg;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) ws_n_last_reg <= 1'b1;
    else ws_n_last_reg <= ws_n_s;
  end

  // Generated configuration clock; slow rate until fast is requested
  logic [3:0] div_reg;
  logic       gclk_reg;
  logic [3:0] half_cnt;
  assign half_cnt = fast_rate ? 4'(`CDP_FAST_HALF - 1)
                              : 4'(`CDP_SLOW_HALF - 1);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg  <= 4'h0;
      gclk_reg <= 1'b0;
    end else if (!is_master || config_done) begin
      div_reg  <= 4'h0;
      gclk_reg <= 1'b0;
    end else if (div_reg >= half_cnt) begin
      div_reg  <= 4'h0;
      gclk_reg <= !gclk_reg;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // Edge detect on the clock actually in use
  logic cfg_clock;
  logic cfg_clock_last_reg;
  logic rise;
  logic fall;
  assign cfg_clock = is_master ? gclk_reg : ext_clk;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) cfg_clock_last_reg <= 1'b0;
    else cfg_clock_last_reg <= cfg_clock;
  end
  assign rise = cfg_clock && !cfg_clock_last_reg;
  assign fall = !cfg_clock && cfg_clock_last_reg;

  // Byte loader: one buffer, shifted out msb first one bit per rising edge
  cdp_state_type state_reg;
  logic [7:0]    shift_reg;
  logic [2:0]    bit_cnt_reg;
  logic          buf_full_reg;
  logic [7:0]    buf_reg;
  logic [21:0]   addr_reg;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      buf_full_reg <= 1'b0;
      buf_reg      <= 8'h00;
    end else if (do_write && ws_n_last_reg && !buf_full_reg) begin
      buf_reg      <= bus_s;
      buf_full_reg <= 1'b1;
    end else if (state_reg == CDP_IDLE && buf_full_reg && is_periph) begin
      buf_full_reg <= 1'b0;
    end
  end

  // Serial path and master parallel fetch; address prepared before use
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= CDP_IDLE;
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 3'h0;
      addr_reg    <= `CDP_ADDR_UP_START;
      frame_bit   <= 1'b0;
      frame_bit_valid <= 1'b0;
    end else begin
      frame_bit_valid <= 1'b0;
      case (state_reg)
        CDP_IDLE: begin
          if (config_done) begin
            state_reg <= CDP_IDLE;
          end else if (is_periph && buf_full_reg) begin
            shift_reg   <= buf_reg;
            bit_cnt_reg <= 3'h0;
            state_reg   <= CDP_SHIFT;
          end else if (is_mpar) begin
            addr_reg  <= (cfg_mode == `CDP_MODE_MPDN) ?
                         `CDP_ADDR_DN_START : `CDP_ADDR_UP_START;
            state_reg <= CDP_FETCH;
          end else if (rise && !is_periph) begin
            // Peripheral modes take their bits from the buffer only
            frame_bit       <= din_s;
            frame_bit_valid <= 1'b1;
          end
        end
        CDP_FETCH: begin
          if (rise) begin
            // Bit zero is the serial input pin itself
            shift_reg   <= {bus_s[7:1], din_s};
            bit_cnt_reg <= 3'h0;
            addr_reg    <= (cfg_mode == `CDP_MODE_MPDN) ?
                           addr_reg - 22'h1 : addr_reg + 22'h1;
            state_reg   <= CDP_SHIFT;
          end
        end
        CDP_SHIFT: begin
          if (rise) begin
            frame_bit       <= shift_reg[7];
            frame_bit_valid <= 1'b1;
            shift_reg       <= {shift_reg[6:0], 1'b0};
            bit_cnt_reg     <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              state_reg <= (is_mpar && !config_done) ? CDP_FETCH : CDP_IDLE;
            end
          end
        end
        default: state_reg <= CDP_IDLE;
      endcase
    end
  end

  // Forward path: bit taken on a rising edge, stepped on the next falling
  // edge after the following rise, giving one and a half periods of delay
  logic hold_a_reg;
  logic hold_b_reg;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hold_a_reg <= 1'b0;
      hold_b_reg <= 1'b0;
    end else if (rise) begin
      hold_a_reg <= din_s;
      hold_b_reg <= hold_a_reg;
    end
  end

  // Pin drivers; every output registered, released after configuration
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      serial_data_out         <= 1'b1;
      serial_data_out_oe_n    <= 1'b1;
      parallel_config_bus_out <= 8'hff;
      parallel_config_bus_oe_n <= 8'hff;
      prom_addr_low           <= 18'h00000;
      prom_addr_high          <= 4'h0;
      prom_addr_oe_n          <= 1'b1;
      cfg_clock_out           <= 1'b0;
      cfg_clock_oe_n          <= 1'b1;
    end else if (config_done) begin
      serial_data_out_oe_n     <= 1'b1;
      parallel_config_bus_oe_n <= 8'hff;
      prom_addr_oe_n           <= 1'b1;
      cfg_clock_oe_n           <= 1'b1;
    end else begin
      serial_data_out_oe_n <= 1'b0;
      if (express_mode) begin
        // Downstream enabled while high select is high with no byte buffered or being shifted
        serial_data_out <= sel_s && (state_reg == CDP_IDLE)
                           && !buf_full_reg;
      end else if (fall) begin
        serial_data_out <= hold_b_reg;
      end
      // Status read: top line ready flag, lower lines high
      parallel_config_bus_out  <= {!buf_full_reg, 7'h7f};
      parallel_config_bus_oe_n <= do_read ? 8'h00 : 8'hff;
      prom_addr_low  <= addr_reg[17:0];
      prom_addr_high <= WIDE_ADDR ? addr_reg[21:18] : 4'h0;
      // Address pins driven only once the start address is loaded
      prom_addr_oe_n <= !(is_mpar && state_reg != CDP_IDLE);
      cfg_clock_out  <= gclk_reg;
      cfg_clock_oe_n <= !is_master;
    end
  end
endmodule

// File: verification/cdp_port_props.sv
// Checker of the configuration data port pin behaviour
`timescale 1ns/100ps
`include "cdp_defines.svh"
module cdp_port_props (
  // Watched ports
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [2:0]  cfg_mode,
  input wire logic        fast_rate,
  input wire logic        config_done,
  input wire logic        select_active_low,
  input wire logic        select_active_high,
  input wire logic        write_strobe_n,
  input wire logic        read_strobe_n,
  input wire logic [7:0]  parallel_config_bus_out,
  input wire logic [7:0]  parallel_config_bus_oe_n,
  input wire logic        serial_data_out_oe_n,
  input wire logic [17:0] prom_addr_low,
  input wire logic [3:0]  prom_addr_high,
  input wire logic        prom_addr_oe_n,
  input wire logic        cfg_clock_out,
  input wire logic        frame_bit_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire [21:0] addr = {prom_addr_high, prom_addr_low};
  wire        up   = cfg_mode == `CDP_MODE_MPUP;
  // Held selected read; five cycles cover the pin synchronisers
  wire rd = select_active_high && !select_active_low && !read_strobe_n &&
    write_strobe_n && !config_done && cfg_mode == `CDP_MODE_PASY;
  a_pins_released: assert property (
    config_done [*3] |-> &{parallel_config_bus_oe_n, serial_data_out_oe_n,
    prom_addr_oe_n}) else $error("pins still driven after done");
  a_status_lines_high: assert property (
    !parallel_config_bus_oe_n[0] |-> parallel_config_bus_out[6:0] == 7'h7f)
    else $error("low data lines not high in status read");
  a_unselected_quiet: assert property (
    select_active_low [*5] |-> &parallel_config_bus_oe_n)
    else $error("bus driven while unselected");
  a_write_wins: assert property (
    !write_strobe_n [*5] |-> &parallel_config_bus_oe_n)
    else $error("bus driven during write");
  a_read_drives: assert property (
    rd [*5] |-> parallel_config_bus_oe_n == 8'h00)
    else $error("status not driven in selected read");
  a_addr_start: assert property (
    $fell(prom_addr_oe_n) |-> addr == (up ? 22'h000000 : 22'h3fffff))
    else $error("wrong first address");
  a_addr_step: assert property (
    !prom_addr_oe_n && !$past(prom_addr_oe_n) && $changed(addr) |->
    addr == (up ? $past(addr) + 22'h1 : $past(addr) - 22'h1))
    else $error("address step not one");
  a_slow_half: assert property (
    $rose(cfg_clock_out) && !fast_rate |=> $stable(cfg_clock_out) [*8])
    else $error("slow clock half period too short");
  c_status_read: cover property (rd [*5]);
  c_frame_bit: cover property (frame_bit_valid);
  c_prom_start: cover property ($fell(prom_addr_oe_n));
endmodule
bind cdp_port cdp_port_props chk_u (.clock, .sys_rst, .cfg_mode, .fast_rate,
  .config_done, .select_active_low, .select_active_high, .write_strobe_n,
  .read_strobe_n, .parallel_config_bus_out, .parallel_config_bus_oe_n,
  .serial_data_out_oe_n, .prom_addr_low, .prom_addr_high, .prom_addr_oe_n,
  .cfg_clock_out, .frame_bit_valid);

// File: verification/cdp_far_model.sv
// Far side model: configuration PROM and upstream serial source
`timescale 1ns/100ps
module cdp_far_model (
  // Link control and PROM address
  input  wire logic        run,
  input  wire logic        par,
  input  wire logic [17:0] addr,
  // Lines toward the device
  output logic      [7:0]  prom_data,
  output logic             link_clk,
  output logic             din
);
  logic [7:0] byte_v;
  logic [3:0] cnt  = 4'h0;
  logic       sbit = 1'b0;
  // Bit zero is wrong on the byte bus so only the serial pin can supply it
  assign byte_v    = addr[7:0] ^ 8'h5a;
  assign prom_data = {byte_v[7:1], ~byte_v[0]};
  assign din = par ? byte_v[0] : (run ? sbit : ~sbit);
  // Link clock stands still outside frames; offset keeps its edges off the clock edges
  initial begin
    link_clk = 1'b0;
    #7;
    forever #160 link_clk = run ? ~link_clk : 1'b0;
  end
  // New bit after each fall, so it is stable at the rise
  always @(negedge link_clk) begin
    sbit <= cnt[0] ^ cnt[2] ^ cnt[3];
    cnt  <= cnt + 4'h1;
  end
endmodule

// File: verification/tb_top.sv
// Self-checking bench of the configuration data port
`timescale 1ns/100ps
`include "cdp_defines.svh"
module tb_top;
  logic clock = 1'b0, sys_rst = 1'b1, express_mode = 1'b0, run = 1'b0;
  logic fast_rate = 1'b0, config_done = 1'b0, par;
  logic select_active_low = 1'b1, select_active_high = 1'b0;
  logic write_strobe_n = 1'b1, read_strobe_n = 1'b1;
  logic [2:0] cfg_mode = `CDP_MODE_PASY;
  logic [7:0] host_data = 8'h00, prom_data, parallel_config_bus_out;
  logic [7:0] parallel_config_bus_in, parallel_config_bus_oe_n;
  logic [17:0] prom_addr_low;
  logic [3:0] prom_addr_high;
  logic serial_data_in, serial_data_out, serial_data_out_oe_n;
  logic cfg_clock_in, cfg_clock_out, cfg_clock_oe_n;
  logic prom_addr_oe_n, frame_bit, frame_bit_valid;
  int miscompares = 0, checked = 0;
  assign par = cfg_mode[2] && !cfg_mode[0];
  assign parallel_config_bus_in = par ? prom_data : host_data;
  cdp_port dut_u (.clock, .sys_rst, .cfg_mode, .express_mode, .fast_rate,
    .config_done, .select_active_low, .select_active_high, .write_strobe_n,
    .read_strobe_n, .parallel_config_bus_in, .parallel_config_bus_out,
    .parallel_config_bus_oe_n, .serial_data_in, .serial_data_out,
    .serial_data_out_oe_n, .cfg_clock_in, .cfg_clock_out, .cfg_clock_oe_n,
    .prom_addr_low, .prom_addr_high, .prom_addr_oe_n, .frame_bit,
    .frame_bit_valid);
  cdp_far_model far_u (.run, .par, .addr(prom_addr_low), .prom_data,
    .link_clk(cfg_clock_in), .din(serial_data_in));
  initial forever #20 clock = ~clock;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Mode pins are decoded every cycle; each mode still starts from reset
  task boot(input logic [2:0] m);
    sys_rst <= 1'b1;
    cfg_mode <= m;
    cyc(10);
    sys_rst <= 1'b0;
    cyc(2);
  endtask
  // Collect n frame bits msb first; the wait is bounded
  task bits(input int n, output logic [15:0] v);
    int w;
    v = 16'h0;
    for (int i = 0; i < n; i++) begin
      w = 0;
      do begin
        @(posedge clock);
        w++;
      end while (frame_bit_valid !== 1'b1 && w < 2000);
      v = {v[14:0], frame_bit};
    end
  endtask
  // One-cycle strobe; the host then polls ready before the next byte
  task t_write;
    logic [15:0] v;
    logic seen;
    boot(`CDP_MODE_PASY);
    select_active_low <= 1'b0;
    select_active_high <= 1'b1;
    host_data <= 8'hb4;
    write_strobe_n <= 1'b0;
    cyc(1);
    write_strobe_n <= 1'b1;
    seen = 1'b0;
    fork
      bits(8, v);
      repeat (8) begin
        @(posedge clock);
        if (parallel_config_bus_out[7] === 1'b0) seen = 1'b1;
      end
    join
    chk(v, 16'h00b4);
    chk({15'h0, seen}, 16'h1);
    read_strobe_n <= 1'b0;
    cyc(5);
    chk({parallel_config_bus_oe_n, parallel_config_bus_out}, 16'h00ff);
    read_strobe_n <= 1'b1;
  endtask
  task t_unsel;
    logic [15:0] v;
    cyc(1);
    select_active_low <= 1'b1;
    read_strobe_n <= 1'b0;
    cyc(6);
    chk({8'h0, parallel_config_bus_oe_n}, 16'h00ff);
    select_active_low <= 1'b0;
    host_data <= 8'h3c;
    write_strobe_n <= 1'b0;
    cyc(6);
    chk({8'h0, parallel_config_bus_oe_n}, 16'h00ff);
    write_strobe_n <= 1'b1;
    read_strobe_n <= 1'b1;
    bits(8, v);
    chk(v, 16'h003c);
  endtask
  task t_express;
    boot(`CDP_MODE_PASY);
    express_mode <= 1'b1;
    select_active_high <= 1'b1;
    cyc(6);
    chk({15'h0, serial_data_out}, 16'h1);
    select_active_high <= 1'b0;
    cyc(6);
    chk({15'h0, serial_data_out}, 16'h0);
    express_mode <= 1'b0;
  endtask
  // Bit taken at rise k shows on the output at rise k plus two
  task t_serial;
    logic        q[$];
    logic [15:0] v;
    logic [15:0] e;
    boot(`CDP_MODE_SSER);
    run <= 1'b1;
    fork
      bits(8, v);
      repeat (12) begin
        @(posedge cfg_clock_in);
        if (q.size() >= 2)
          chk({15'h0, serial_data_out}, {15'h0, q[q.size()-2]});
        q.push_back(serial_data_in);
      end
    join
    // Frame bits are the first eight bits seen at the link rises
    e = 16'h0;
    for (int i = 0; i < 8; i++) e = {e[14:0], q[i]};
    chk(v, e);
    chk({15'h0, cfg_clock_oe_n}, 16'h1);
    @(posedge clock);
    run <= 1'b0;
  endtask
  // Edges from one rise of the generated clock to the next, bounded
  task period(output logic [15:0] n);
    logic last;
    int   r;
    n = 16'h0;
    r = 0;
    last = cfg_clock_out;
    for (int i = 0; i < 200 && r < 2; i++) begin
      @(posedge clock);
      if (r == 1) n = n + 16'h1;
      if (cfg_clock_out === 1'b1 && last === 1'b0) r++;
      last = cfg_clock_out;
    end
  endtask
  // Generated clock: slow after reset, fast once requested
  task t_clock;
    logic [15:0] n;
    boot(`CDP_MODE_MPUP);
    chk({14'h0, cfg_clock_oe_n, serial_data_out_oe_n}, 16'h0);
    period(n);
    chk(n, 16'(2 * `CDP_SLOW_HALF));
    // Switch only after the checked slow high phase has passed
    cyc(8);
    fast_rate <= 1'b1;
    cyc(4);
    period(n);
    chk(n, 16'(2 * `CDP_FAST_HALF));
    fast_rate <= 1'b0;
  endtask
  task t_master;
    logic [15:0] v;
    boot(`CDP_MODE_MPUP);
    bits(16, v);
    chk(v, 16'h5a5b);
    boot(`CDP_MODE_MPDN);
    bits(8, v);
    chk(v, 16'h00a5);
    chk({15'h0, prom_addr_oe_n}, 16'h0);
    chk({12'h0, prom_addr_high}, 16'h000f);
    config_done <= 1'b1;
    cyc(4);
    chk({6'h3f, parallel_config_bus_oe_n, prom_addr_oe_n,
      serial_data_out_oe_n}, 16'hffff);
    config_done <= 1'b0;
  endtask
  task conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    t_write;
    t_unsel;
    t_express;
    t_serial;
    t_clock;
    t_master;
    conclude;
  end
  // Watchdog: the tests need well under half of this span
  initial begin
    #2000000;
    miscompares++;
    conclude;
  end
endmodule
